// File: rtl/dpclp_pkg.sv
// Package for the digital power control loop: register map, fields, resets, timing.
// Assumes a single 250 MHz APB clock; all counts below derive from CLK_NS.
package dpclp_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_REF    = 8'h04;
	localparam logic [7:0] OFS_PID_A  = 8'h08;
	localparam logic [7:0] OFS_PID_B  = 8'h0C;
	localparam logic [7:0] OFS_PID_C  = 8'h10;
	localparam logic [7:0] OFS_LPF    = 8'h14;
	localparam logic [7:0] OFS_DEC    = 8'h18;
	localparam logic [7:0] OFS_PERIOD = 8'h1C;
	localparam logic [7:0] OFS_DUTY   = 8'h20;
	localparam logic [7:0] OFS_ILIM   = 8'h24;
	localparam logic [7:0] OFS_STOP   = 8'h28;
	localparam logic [7:0] OFS_STAT   = 8'h2C;
	localparam logic [7:0] OFS_TRANS  = 8'h30;
	// Control register fields
	localparam int C_RUN    = 0;
	localparam int C_EN_POL = 1;
	localparam int C_EN_PIN = 2;
	localparam int C_SYNC   = 3;
	localparam int C_PSM    = 4;
	localparam int C_CPU    = 5;
	localparam int C_COMB   = 6;
	localparam int C_DITH   = 7;
	localparam int C_RATE   = 8;
	localparam int C_LSB    = 10;
	localparam int C_REFEXT = 12;
	localparam int C_BYP    = 13;
	// Status fields
	localparam int S_TRANS = 0;
	localparam int S_OCP   = 1;
	localparam int S_CNT   = 8;
	localparam int S_DUTY  = 16;
	// Reset values
	localparam logic [15:0] RST_CTRL   = 16'h0000;
	localparam logic [11:0] RST_PERIOD = 12'h271;
	localparam logic [15:0] RST_LPF    = 16'h4040;
	localparam logic [15:0] RST_ILIM   = 16'h080F;
	localparam logic [9:0]  RST_TRANS  = 10'h040;
	// Timing: clock period and sample periods for the four rate codes
	localparam int CLK_NS    = 4;
	localparam int SMP_NS_0  = 800;
	localparam int SMP_NS_1  = 400;
	localparam int SMP_NS_2  = 200;
	localparam int SMP_NS_3  = 100;
	localparam int SMP_CYC_0 = SMP_NS_0 / CLK_NS;
	localparam int SMP_CYC_1 = SMP_NS_1 / CLK_NS;
	localparam int SMP_CYC_2 = SMP_NS_2 / CLK_NS;
	localparam int SMP_CYC_3 = SMP_NS_3 / CLK_NS;
	// Leading-edge blanking times, least times so rounded up
	localparam int BLK_NS_0  = 40;
	localparam int BLK_NS_1  = 80;
	localparam int BLK_NS_2  = 160;
	localparam int BLK_NS_3  = 320;
	localparam int BLK_CYC_0 = (BLK_NS_0 + CLK_NS - 1) / CLK_NS;
	localparam int BLK_CYC_1 = (BLK_NS_1 + CLK_NS - 1) / CLK_NS;
	localparam int BLK_CYC_2 = (BLK_NS_2 + CLK_NS - 1) / CLK_NS;
	localparam int BLK_CYC_3 = (BLK_NS_3 + CLK_NS - 1) / CLK_NS;
	// Filter scaling
	localparam int PID_SHIFT = 12;
	localparam int LPF_SHIFT = 8;
endpackage

// File: rtl/dpclp_mod.sv
// Digital pulse modulator core: switching counter, PWM or phase-shift phases,
// sync restart, leading-edge blanking and cycle truncation on a current trip.
// Assumes trip and sync_pulse are already synchronised to clk.
module dpclp_mod (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        run,
	input  wire logic [11:0] period,
	input  wire logic [11:0] duty,
	input  wire logic        psm,
	input  wire logic        sync_pulse,
	input  wire logic        trip,
	input  wire logic [7:0]  blank_cyc,
	output logic      [3:0]  ph,
	output logic             cyc_end,
	output logic             cyc_trip
);
	logic [11:0] cnt_r;
	logic [7:0]  blank_r;
	logic        tripped_r;
	logic        start;
	logic        trip_hit;
	logic [11:0] half;
	logic [11:0] shifted;
	logic        a;
	logic        b;

	// A cycle ends at the period count or at an external sync edge
	assign start    = sync_pulse | (cnt_r >= period - 12'h001);
	assign cyc_end  = run & start;
	// Trips inside the blanking window are ignored
	assign trip_hit = run & trip & (blank_r == 8'h00);
	assign cyc_trip = tripped_r | trip_hit;
	assign half     = period >> 1;
	assign shifted  = (cnt_r >= duty) ? cnt_r - duty : cnt_r + period - duty;

	// Switching counter, restarted in step with sync
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			cnt_r <= 12'h000;
		else if (!run || start)
			cnt_r <= 12'h000;
		else
			cnt_r <= cnt_r + 12'h001;

	// Blanking timer reloads on each leading edge
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			blank_r <= 8'h00;
		else if (!run || start)
			blank_r <= blank_cyc;
		else if (blank_r != 8'h00)
			blank_r <= blank_r - 8'h01;

	// Trip holds the outputs off until the cycle ends
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			tripped_r <= 1'b0;
		else if (start)
			tripped_r <= 1'b0;
		else if (trip_hit)
			tripped_r <= 1'b1;

	// Phase generation; the trip mask acts in the same cycle
	always_comb
	begin
		if (psm)
		begin
			a = cnt_r < half;
			b = shifted < half;
		end
		else
		begin
			a = cnt_r < duty;
			b = a;
		end
		ph = {~b, b, ~a, a};
		if (cyc_trip)
			ph = 4'h0;
	end
endmodule // dpclp_mod

// File: rtl/dpclp_top.sv
// Control-loop datapath of a digital switched-mode power controller, APB slave.
// Assumes an external loop converter, reference DAC, current comparator and
// gate drivers; all pins from them are asynchronous to pclk.
// Summary of operation
// - Converter rate chosen from four settings
// - Error sample scaled by programmable LSB size
// - Load transient raises interrupt flag
// - Nine-bit reference code, internal or external
// - PID stage: one pole, two zeros
// - Second stage: low-pass or comb
// - Comb decimation ratio set by software
// - Six parameters change live without stopping
// - Optional random one-LSB dither on duty
// - Four-bit current limit threshold
// - Trips ignored during selectable blanking time
// - Current trip ends active modulated outputs at once; bypass-forced outputs keep their level
// - Consecutive limit cycles reaching maximum shut down
// - PWM or phase-shift output modes
// - Duty from filter or from CPU
// - Separate stop levels for disable and overcurrent
// - Bypass forces selected outputs, others modulate
// - Enable input with selectable polarity, routable
// - Sync input restarts each switching cycle
// - Filter output code sets output timing
//
// The placing of the registers and the APB register port were decided locally.
module dpclp_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [9:0]  adc_data,
	input  wire logic        adc_done,
	output logic             adc_start,
	output logic      [8:0]  loop_reference_dac_code,
	output logic             loop_reference_dac_ext,
	output logic      [3:0]  ilim_code,
	input  wire logic        ipk_trip,
	input  wire logic        en_pin,
	input  wire logic        sync_pin,
	output logic      [3:0]  gate,
	output logic             transient_irq
);
	logic [13:0]        pin_s1_r, pin_s2_r;
	logic               done_d_r, sync_d_r;
	logic [15:0]        ctrl_r, lpf_r, ilim_r, stop_r;
	logic [15:0]        pid_a_r, pid_b_r, pid_c_r;
	logic [15:0]        sh_a_r, sh_b_r, sh_c_r, sh_lpf_r;
	logic [2:0]         dec_r, sh_dec_r;
	logic [8:0]         ref_r;
	logic [11:0]        period_r, cpu_duty_r, duty_r;
	logic [9:0]         trans_thr_r;
	logic               ocp_r;
	logic [7:0]         ocp_cnt_r;
	logic [7:0]         rate_cnt_r;
	logic [15:0]        lfsr_r;
	logic signed [15:0] e1_r, e2_r, w1_r, w2_r, comb_y_r;
	logic signed [35:0] pid_acc_r, comb_sum_r;
	logic [6:0]         comb_cnt_r;
	logic               wr, rd_setup, smp, sync_pulse, enabled, mod_run;
	logic signed [15:0] err, pid_y;
	logic signed [35:0] pid_nxt;
	logic [9:0]         err_mag;
	logic [7:0]         rate_len, blank_cyc;
	logic [6:0]         comb_last;
	logic [3:0]         mod_ph;
	logic               cyc_end, cyc_trip;
	logic [11:0]        duty_nxt;
	logic signed [15:0] u;

	// Address match, used by both the write and the read decoders
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// Clamp a wide accumulator to the 16-bit datapath
	function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
		if (v > 36'sh000007FFF)
			return 16'sh7FFF;
		else if (v < -36'sh000008000)
			return -16'sh8000;
		else
			return v[15:0];
	endfunction

	// Two-flop synchronisers for every pin input
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pin_s1_r <= 14'h0000;
			pin_s2_r <= 14'h0000;
		end
		else
		begin
			pin_s1_r <= {sync_pin, en_pin, ipk_trip, adc_done, adc_data};
			pin_s2_r <= pin_s1_r;
		end

	// Edge detectors look only at the second stage
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			done_d_r <= 1'b0;
			sync_d_r <= 1'b0;
		end
		else
		begin
			done_d_r <= pin_s2_r[10];
			sync_d_r <= pin_s2_r[13];
		end

	assign smp        = pin_s2_r[10] & ~done_d_r;
	assign sync_pulse = ctrl_r[dpclp_pkg::C_SYNC] & pin_s2_r[13] & ~sync_d_r;
	// Enable pin is qualified by its polarity; software run gates both routes
	assign enabled = ctrl_r[dpclp_pkg::C_RUN] & (~ctrl_r[dpclp_pkg::C_EN_PIN] |
		(pin_s2_r[12] == ctrl_r[dpclp_pkg::C_EN_POL]));
	assign mod_run = enabled & ~ocp_r;

	// APB: zero wait states, setup phase prepares read data
	assign wr       = psel & penable & pready & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;

	// Configuration registers; software writes only
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl_r      <= dpclp_pkg::RST_CTRL;
			ref_r       <= 9'h000;
			pid_a_r     <= 16'h0000;
			pid_b_r     <= 16'h0000;
			pid_c_r     <= 16'h0000;
			lpf_r       <= dpclp_pkg::RST_LPF;
			dec_r       <= 3'h0;
			period_r    <= dpclp_pkg::RST_PERIOD;
			cpu_duty_r  <= 12'h000;
			ilim_r      <= dpclp_pkg::RST_ILIM;
			stop_r      <= 16'h0000;
			trans_thr_r <= dpclp_pkg::RST_TRANS;
		end
		else if (wr)
		begin
			if (hit(paddr, dpclp_pkg::OFS_CTRL))   ctrl_r      <= pwdata[15:0];
			if (hit(paddr, dpclp_pkg::OFS_REF))    ref_r       <= pwdata[8:0];
			if (hit(paddr, dpclp_pkg::OFS_PID_A))  pid_a_r     <= pwdata[15:0];
			if (hit(paddr, dpclp_pkg::OFS_PID_B))  pid_b_r     <= pwdata[15:0];
			if (hit(paddr, dpclp_pkg::OFS_PID_C))  pid_c_r     <= pwdata[15:0];
			if (hit(paddr, dpclp_pkg::OFS_LPF))    lpf_r       <= pwdata[15:0];
			if (hit(paddr, dpclp_pkg::OFS_DEC))    dec_r       <= pwdata[2:0];
			if (hit(paddr, dpclp_pkg::OFS_PERIOD)) period_r    <= pwdata[11:0];
			if (hit(paddr, dpclp_pkg::OFS_DUTY))   cpu_duty_r  <= pwdata[11:0];
			if (hit(paddr, dpclp_pkg::OFS_ILIM))   ilim_r      <= pwdata[15:0];
			if (hit(paddr, dpclp_pkg::OFS_STOP))   stop_r      <= pwdata[15:0];
			if (hit(paddr, dpclp_pkg::OFS_TRANS))  trans_thr_r <= pwdata[9:0];
		end

	// Read data and error answer, captured in the setup phase
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
			pready  <= 1'b0;
		end
		else
		begin
			pready <= 1'b1;
			if (psel & ~penable)
				pslverr <= paddr > dpclp_pkg::OFS_TRANS || paddr[1:0] != 2'h0;
			if (rd_setup)
			begin
				prdata <= 32'h00000000;
				if (hit(paddr, dpclp_pkg::OFS_CTRL))   prdata[15:0] <= ctrl_r;
				if (hit(paddr, dpclp_pkg::OFS_REF))    prdata[8:0]  <= ref_r;
				if (hit(paddr, dpclp_pkg::OFS_PID_A))  prdata[15:0] <= pid_a_r;
				if (hit(paddr, dpclp_pkg::OFS_PID_B))  prdata[15:0] <= pid_b_r;
				if (hit(paddr, dpclp_pkg::OFS_PID_C))  prdata[15:0] <= pid_c_r;
				if (hit(paddr, dpclp_pkg::OFS_LPF))    prdata[15:0] <= lpf_r;
				if (hit(paddr, dpclp_pkg::OFS_DEC))    prdata[2:0]  <= dec_r;
				if (hit(paddr, dpclp_pkg::OFS_PERIOD)) prdata[11:0] <= period_r;
				if (hit(paddr, dpclp_pkg::OFS_DUTY))   prdata[11:0] <= cpu_duty_r;
				if (hit(paddr, dpclp_pkg::OFS_ILIM))   prdata[15:0] <= ilim_r;
				if (hit(paddr, dpclp_pkg::OFS_STOP))   prdata[15:0] <= stop_r;
				if (hit(paddr, dpclp_pkg::OFS_TRANS))  prdata[9:0]  <= trans_thr_r;
				if (hit(paddr, dpclp_pkg::OFS_STAT))
					prdata <= {4'h0, duty_r, ocp_cnt_r, 6'h00, ocp_r, transient_irq};
			end
		end

	// Conversion strobe at the selected sample rate
	always_comb
		case (ctrl_r[dpclp_pkg::C_RATE +: 2])
			2'h0:    rate_len = 8'(dpclp_pkg::SMP_CYC_0);
			2'h1:    rate_len = 8'(dpclp_pkg::SMP_CYC_1);
			2'h2:    rate_len = 8'(dpclp_pkg::SMP_CYC_2);
			default: rate_len = 8'(dpclp_pkg::SMP_CYC_3);
		endcase

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			rate_cnt_r <= 8'h00;
			adc_start  <= 1'b0;
		end
		else
		begin
			adc_start  <= rate_cnt_r == 8'h00;
			rate_cnt_r <= (rate_cnt_r >= rate_len - 8'h01) ? 8'h00 : rate_cnt_r + 8'h01;
		end

	// Pin-facing static outputs
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			loop_reference_dac_code <= 9'h000;
			loop_reference_dac_ext  <= 1'b0;
			ilim_code   <= 4'h0;
		end
		else
		begin
			loop_reference_dac_code <= ref_r;
			loop_reference_dac_ext  <= ctrl_r[dpclp_pkg::C_REFEXT];
			ilim_code   <= ilim_r[3:0];
		end

	// Error sample: converter output widened, then coarsened by the LSB code
	assign err     = $signed({{6{pin_s2_r[9]}}, pin_s2_r[9:0]}) >>> ctrl_r[dpclp_pkg::C_LSB +: 2];
	assign err_mag = err[15] ? 10'(-err) : err[9:0];

	// Transient flag; a new event wins over a same-cycle clear
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			transient_irq <= 1'b0;
		else if (smp && err_mag > trans_thr_r)
			transient_irq <= 1'b1;
		else if (wr && hit(paddr, dpclp_pkg::OFS_STAT) && pwdata[dpclp_pkg::S_TRANS])
			transient_irq <= 1'b0;

	// Coefficients are taken on a sample edge, so a live update never tears
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sh_a_r   <= 16'h0000;
			sh_b_r   <= 16'h0000;
			sh_c_r   <= 16'h0000;
			sh_lpf_r <= dpclp_pkg::RST_LPF;
			sh_dec_r <= 3'h0;
		end
		else if (smp)
		begin
			sh_a_r   <= pid_a_r;
			sh_b_r   <= pid_b_r;
			sh_c_r   <= pid_c_r;
			sh_lpf_r <= lpf_r;
			sh_dec_r <= dec_r;
		end

	// PID: integrator pole plus two zeros from three taps
	assign pid_nxt = pid_acc_r + 36'($signed(sh_a_r) * err) + 36'($signed(sh_b_r) * e1_r)
		+ 36'($signed(sh_c_r) * e2_r);
	assign pid_y = sat16(pid_acc_r >>> dpclp_pkg::PID_SHIFT);

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			e1_r      <= 16'sh0000;
			e2_r      <= 16'sh0000;
			pid_acc_r <= 36'sh000000000;
		end
		else if (smp)
		begin
			e1_r      <= err;
			e2_r      <= e1_r;
			pid_acc_r <= pid_nxt;
		end

	// Two cascaded first-order sections form the two-pole low-pass
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			w1_r <= 16'sh0000;
			w2_r <= 16'sh0000;
		end
		else if (smp)
		begin
			w1_r <= sat16(36'(w1_r) + ((36'(pid_y - w1_r) * $signed({1'b0, sh_lpf_r[7:0]}))
				>>> dpclp_pkg::LPF_SHIFT));
			w2_r <= sat16(36'(w2_r) + ((36'(w1_r - w2_r) * $signed({1'b0, sh_lpf_r[15:8]}))
				>>> dpclp_pkg::LPF_SHIFT));
		end

	// Comb decimator: boxcar sum over 2**code samples, one result per block
	assign comb_last = 7'((8'h01 << sh_dec_r) - 8'h01);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			comb_cnt_r <= 7'h00;
			comb_sum_r <= 36'sh000000000;
			comb_y_r   <= 16'sh0000;
		end
		else if (smp)
		begin
			if (comb_cnt_r >= comb_last)
			begin
				comb_cnt_r <= 7'h00;
				comb_sum_r <= 36'sh000000000;
				comb_y_r   <= sat16((comb_sum_r + 36'(pid_y)) >>> sh_dec_r);
			end
			else
			begin
				comb_cnt_r <= comb_cnt_r + 7'h01;
				comb_sum_r <= comb_sum_r + 36'(pid_y);
			end
		end

	// Noise source for dither
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			lfsr_r <= 16'hACE1;
		else
			lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[14] ^ lfsr_r[12] ^ lfsr_r[3]};

	// Duty selection, clamp to the period, then one-LSB dither
	always_comb
	begin
		u = ctrl_r[dpclp_pkg::C_COMB] ? comb_y_r : w2_r;
		if (u[15])
			duty_nxt = 12'h000;
		else if (u > $signed({4'h0, period_r}))
			duty_nxt = period_r;
		else
			duty_nxt = u[11:0];
		if (ctrl_r[dpclp_pkg::C_CPU])
			duty_nxt = (cpu_duty_r > period_r) ? period_r : cpu_duty_r;
		if (ctrl_r[dpclp_pkg::C_DITH] && lfsr_r[0] && duty_nxt < period_r)
			duty_nxt = duty_nxt + 12'h001;
	end

	// Duty is updated at a cycle boundary to avoid runt pulses, and on every clock while the modulator is stopped
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			duty_r <= 12'h000;
		else if (cyc_end || !mod_run)
			duty_r <= duty_nxt;

	always_comb
		case (ilim_r[5:4])
			2'h0:    blank_cyc = 8'(dpclp_pkg::BLK_CYC_0);
			2'h1:    blank_cyc = 8'(dpclp_pkg::BLK_CYC_1);
			2'h2:    blank_cyc = 8'(dpclp_pkg::BLK_CYC_2);
			default: blank_cyc = 8'(dpclp_pkg::BLK_CYC_3);
		endcase

	dpclp_mod u_mod (
		.clk        (pclk),
		.rst_n      (presetn),
		.run        (mod_run),
		.period     (period_r),
		.duty       (duty_r),
		.psm        (ctrl_r[dpclp_pkg::C_PSM]),
		.sync_pulse (sync_pulse),
		.trip       (pin_s2_r[11]),
		.blank_cyc  (blank_cyc),
		.ph         (mod_ph),
		.cyc_end    (cyc_end),
		.cyc_trip   (cyc_trip)
	);

	// Consecutive limit counter and latched shutdown; trip set beats clear
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ocp_cnt_r <= 8'h00;
			ocp_r     <= 1'b0;
		end
		else
		begin
			if (cyc_end && !cyc_trip)
				ocp_cnt_r <= 8'h00;
			else if (cyc_end)
				ocp_cnt_r <= ocp_cnt_r + 8'h01;
			if (cyc_end && cyc_trip && ocp_cnt_r + 8'h01 == ilim_r[15:8] && ilim_r[15:8] != 8'h00)
				ocp_r <= 1'b1;
			else if (wr && hit(paddr, dpclp_pkg::OFS_STAT) && pwdata[dpclp_pkg::S_OCP])
				ocp_r <= 1'b0;
		end

	// Output priority: overcurrent stop, disable stop, bypass, modulation
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			gate <= 4'h0;
		else if (ocp_r)
			gate <= stop_r[7:4];
		else if (!enabled)
			gate <= stop_r[3:0];
		else if (ctrl_r[dpclp_pkg::C_BYP])
			gate <= (stop_r[11:8] & stop_r[15:12]) | (~stop_r[11:8] & mod_ph);
		else
			gate <= mod_ph;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ocp_stop_lvl: assert property (ocp_r |=> gate == $past(stop_r[7:4]))
		else $error("gate not at overcurrent stop level");
	a_dis_stop_lvl: assert property (!ocp_r && !enabled |=> gate == $past(stop_r[3:0]))
		else $error("gate not at disable stop level");
	a_clean_cycle_clr: assert property (cyc_end && !cyc_trip |=> ocp_cnt_r == 8'h00)
		else $error("limit count not cleared after clean cycle");
	a_ocp_reach_max: assert property (cyc_end && cyc_trip && ilim_r[15:8] != 8'h00
		&& ocp_cnt_r + 8'h01 == ilim_r[15:8] |=> ocp_r ##1 gate == $past(stop_r[7:4]))
		else $error("overcurrent shutdown missed");
	a_trip_truncate: assert property (mod_run && !ctrl_r[dpclp_pkg::C_BYP] && cyc_trip
		|=> gate == 4'h0)
		else $error("outputs not ended on current trip");
	a_trans_flag: assert property (smp && err_mag > trans_thr_r |=> transient_irq)
		else $error("transient not flagged");
	a_rate_fast: assert property (ctrl_r[9:8] == 2'h3 && $stable(ctrl_r) && adc_start
		|=> !adc_start [*8])
		else $error("conversion strobes too close");
	a_duty_bound: assert property (mod_run && cyc_end |=> duty_r <= $past(period_r))
		else $error("duty above period");
	a_bypass_force: assert property (enabled && !ocp_r && ctrl_r[dpclp_pkg::C_BYP]
		&& stop_r[8] |=> gate[0] == $past(stop_r[12]))
		else $error("bypass output not forced");

	c_ocp_shut: cover property (!ocp_r ##1 ocp_r);
	c_trip_cycle: cover property (cyc_end && cyc_trip);
	c_comb_out: cover property (smp && ctrl_r[dpclp_pkg::C_COMB] && comb_cnt_r == comb_last);
endmodule // dpclp_top

// File: tb/dpclp_stage.sv
// Far-side model: loop converter answering adc_start, peak current comparator.
// Assumes the device clock pclk; trip_en makes the switch current run high.
module dpclp_stage (
	input  wire logic       pclk,
	input  wire logic       adc_start,
	input  wire logic [3:0] gate,
	input  wire logic       trip_en,
	output logic      [9:0] adc_data,
	output logic            adc_done,
	output logic            ipk_trip
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r = 4'h0;
	initial adc_data = 10'h000;
	initial adc_done = 1'b0;
	// Result set at start; done rises 4 cycles later so the synced bus is settled
	always @(posedge pclk)
	begin
		if (adc_start)
		begin
			cnt_r    <= 4'h1;
			adc_data <= 10'h010;
		end
		else if (cnt_r != 4'h0)
			cnt_r <= cnt_r + 4'h1;
		adc_done <= (cnt_r >= 4'h4) && (cnt_r < 4'hA);
	end
	// Current only builds while the main switch conducts
	assign ipk_trip = trip_en & gate[0];
endmodule // dpclp_stage

// File: tb/dpclp_top_tb_top.sv
// Self-checking bench for the control-loop block, APB master tasks.
// Assumes dpclp_stage as the power stage; sync input is driven by a free-running source.
module dpclp_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, en_pin = 1'b0, trip_en = 1'b0, sync_pin = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rv, c0, c1;
	logic        pready, pslverr, re, adc_done, adc_start, loop_reference_dac_ext, ipk_trip;
	logic [9:0]  adc_data;
	logic [8:0]  loop_reference_dac_code;
	logic [3:0]  ilim_code, gate;
	logic        transient_irq;
	int          fails = 0, n_compared = 0;
	logic [7:0]  ra [5] = '{dpclp_pkg::OFS_CTRL, dpclp_pkg::OFS_PERIOD,
		dpclp_pkg::OFS_LPF, dpclp_pkg::OFS_ILIM, dpclp_pkg::OFS_TRANS};
	logic [31:0] rx [5] = '{32'h0, 32'h271, 32'h4040, 32'h80F, 32'h40};
	dpclp_top dpclp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_data(adc_data),
		.adc_done(adc_done), .adc_start(adc_start), .loop_reference_dac_code(loop_reference_dac_code),
		.loop_reference_dac_ext(loop_reference_dac_ext), .ilim_code(ilim_code), .ipk_trip(ipk_trip),
		.en_pin(en_pin), .sync_pin(sync_pin), .gate(gate), .transient_irq(transient_irq));
	dpclp_stage dpclp_stage_inst (.pclk(pclk), .adc_start(adc_start), .gate(gate),
		.trip_en(trip_en), .adc_data(adc_data), .adc_done(adc_done), .ipk_trip(ipk_trip));
	// Clock, 4 ns period
	initial
		forever #2 pclk = ~pclk;
	// External sync source: a rising edge every 25 cycles, ignored until enabled
	initial
		forever
		begin
			repeat (13) @(posedge pclk);
			sync_pin <= 1'b1;
			repeat (12) @(posedge pclk);
			sync_pin <= 1'b0;
		end
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rv = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Counts high cycles of gate[0] and gate[1] over n cycles, after settling
	task automatic cnt(input int n);
		repeat (3 * n) @(negedge pclk);
		c0 = 0;
		c1 = 0;
		repeat (n) @(negedge pclk)
		begin
			c0 = c0 + gate[0];
			c1 = c1 + gate[1];
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog: the sequence needs well under 10000 cycles
	initial
	begin
		#100000;
		fails++;
		end_of_test();
	end
	// Main sequence
	initial
	begin
		int d [3] = '{0, 5, 19};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ra[i])
		begin
			apb(1'b0, ra[i], 32'h0);
			chk(rv, rx[i]);
		end
		apb(1'b0, 8'h34, 32'h0);
		chk({re, rv[30:0]}, 32'h80000000);
		apb(1'b1, dpclp_pkg::OFS_REF, 32'h1AB);
		apb(1'b1, dpclp_pkg::OFS_CTRL, 32'h1000);
		apb(1'b1, dpclp_pkg::OFS_ILIM, 32'h307);
		// Pin outputs trail the register write by one clock
		repeat (2) @(negedge pclk);
		chk({loop_reference_dac_ext, ilim_code, loop_reference_dac_code}, {1'b1, 4'h7, 9'h1AB});
		// Converter rate code 3: start pulses 25 cycles apart
		apb(1'b1, dpclp_pkg::OFS_CTRL, 32'h321);
		@(negedge pclk iff adc_start === 1'b1);
		c0 = 1;
		while (c0 < 300)
		begin
			@(negedge pclk);
			if (adc_start === 1'b1)
				break;
			c0++;
		end
		chk(c0, 32'(dpclp_pkg::SMP_CYC_3));
		// Error of 16 against threshold 8 flags; LSB code 2 cuts it to 4
		apb(1'b1, dpclp_pkg::OFS_TRANS, 32'h8);
		cnt(20);
		apb(1'b0, dpclp_pkg::OFS_STAT, 32'h0);
		chk({rv[0], transient_irq}, 2'h3);
		apb(1'b1, dpclp_pkg::OFS_CTRL, 32'hB21);
		apb(1'b1, dpclp_pkg::OFS_STAT, 32'h1);
		cnt(20);
		chk(transient_irq, 1'b0);
		// CPU duty in pulse-width mode, boundary duties
		apb(1'b1, dpclp_pkg::OFS_PERIOD, 32'd20);
		apb(1'b1, dpclp_pkg::OFS_STOP, 32'hA5);
		foreach (d[i])
		begin
			apb(1'b1, dpclp_pkg::OFS_DUTY, d[i]);
			cnt(20);
			chk({c0[15:0], c1[15:0]}, {16'(d[i]), 16'(20 - d[i])});
		end
		apb(1'b1, dpclp_pkg::OFS_CTRL, 32'h31);
		cnt(20);
		chk(c0, 32'd10);
		apb(1'b1, dpclp_pkg::OFS_CTRL, 32'h20);
		cnt(4);
		chk(gate, 4'h5);
		// Bypass forces gate[0] high, gate[1] keeps modulating
		apb(1'b1, dpclp_pkg::OFS_STOP, 32'h11A5);
		apb(1'b1, dpclp_pkg::OFS_CTRL, 32'h2021);
		cnt(20);
		chk({c0[15:0], c1[15:0]}, {16'd20, 16'd1});
		// Enable pin, active low then active high
		apb(1'b1, dpclp_pkg::OFS_STOP, 32'hA5);
		en_pin <= 1'b1;
		apb(1'b1, dpclp_pkg::OFS_CTRL, 32'h25);
		cnt(4);
		chk(gate, 4'h5);
		en_pin <= 1'b0;
		cnt(20);
		chk(c0, 32'd19);
		apb(1'b1, dpclp_pkg::OFS_CTRL, 32'h27);
		cnt(4);
		chk(gate, 4'h5);
		// Current trip truncates the pulse, three in a row shut down
		apb(1'b1, dpclp_pkg::OFS_PERIOD, 32'd40);
		apb(1'b1, dpclp_pkg::OFS_DUTY, 32'd30);
		apb(1'b1, dpclp_pkg::OFS_CTRL, 32'h21);
		cnt(40);
		apb(1'b1, dpclp_pkg::OFS_ILIM, 32'h30F);
		trip_en <= 1'b1;
		@(negedge pclk iff gate[0] === 1'b0);
		@(negedge pclk iff gate[0] === 1'b1);
		c0 = 0;
		repeat (40) @(negedge pclk)
			c0 = c0 + gate[0];
		chk(32'(c0 >= 10 && c0 < 30), 32'h1);
		cnt(40);
		chk(gate, 4'hA);
		apb(1'b0, dpclp_pkg::OFS_STAT, 32'h0);
		chk(rv[1], 1'b1);
		trip_en <= 1'b0;
		apb(1'b1, dpclp_pkg::OFS_STAT, 32'h2);
		apb(1'b0, dpclp_pkg::OFS_STAT, 32'h0);
		chk(rv[1], 1'b0);
		cnt(40);
		chk(c0, 32'd30);
		apb(1'b0, dpclp_pkg::OFS_STAT, 32'h0);
		chk(rv[15:8], 8'h00);
		// Sync every 25 cycles overrides the 40-cycle period
		apb(1'b1, dpclp_pkg::OFS_DUTY, 32'd10);
		apb(1'b1, dpclp_pkg::OFS_CTRL, 32'h29);
		cnt(100);
		chk(c0, 32'd40);
		// Integrating first stage, set while running, drives duty up to the period
		apb(1'b1, dpclp_pkg::OFS_CTRL, 32'h301);
		apb(1'b1, dpclp_pkg::OFS_PID_A, 32'h1000);
		cnt(250);
		apb(1'b0, dpclp_pkg::OFS_STAT, 32'h0);
		chk(rv[27:16], 12'd40);
		end_of_test();
	end
endmodule // dpclp_top_tb_top
